// *** pkg/irq_ctrl_regs.vh ***
/*
 register map, field layout, reset values, vector types and timing for
 the interrupt source arbitration block. assumes a 32-bit apb slave.
*/
`ifndef IRQ_CTRL_REGS_VH
`define IRQ_CTRL_REGS_VH
// register word indices; byte address is index shifted by ADDR_SHIFT
`define OFF_VECTOR 12'h020
`define OFF_EOS 12'h022
`define OFF_MASK 12'h028
`define OFF_PRIMASK 12'h02a
`define OFF_INSERV 12'h02c
`define OFF_REQ 12'h02e
`define OFF_STATUS 12'h030
`define OFF_TMR_CTL 12'h032
`define OFF_DMA0_CTL 12'h034
`define OFF_DMA1_CTL 12'h036
`define OFF_EXTA_CTL 12'h038
`define OFF_EXTB_CTL 12'h03a
`define OFF_EXTC_CTL 12'h03c
`define OFF_EXTD_CTL 12'h03e
`define OFF_MODE 12'h040
// address index: printed offsets are not all multiples of four
`define ADDR_SHIFT 2
// control register fields
`define CTL_PRI_LSB 0
`define CTL_PRI_MSB 2
`define CTL_MASK_BIT 3
`define CTL_LEVEL_BIT 4
`define CTL_CASC_BIT 5
`define CTL_NEST_BIT 6
`define CTL_RST 7'h0f
`define PRIMASK_RST 3'h7
`define VECTOR_RST 5'h00
// source indices in the seven-bit request vector
`define SRC_TMR 0
`define SRC_DMA0 1
`define SRC_DMA1 2
`define SRC_EXTA 3
`define SRC_EXTB 4
`define SRC_EXTC 5
`define SRC_EXTD 6
`define NSRC 7
// fixed master types
`define TYPE_TMR0 8'h08
`define TYPE_TMR1 8'h12
`define TYPE_TMR2 8'h13
`define TYPE_DMA0 8'h0a
`define TYPE_DMA1 8'h0b
`define TYPE_EXTA 8'h0c
`define TYPE_EXTB 8'h0d
`define TYPE_EXTC 8'h0e
`define TYPE_EXTD 8'h0f
// response times in clocks
`define RESP_INTERNAL 42
`define RESP_EXTERNAL 55
`define IDLE_STATES 2
`endif

// *** rtl/irq_source_arbitration_response.v ***
/*
 interrupt source arbitration and acknowledge response logic.
 assumes cpu core drives i_ack_req for one cycle when taking the
 interrupt, and the bus returns i_bus_ready during acknowledge cycles.
*/
// Overview of operation
// [R1] timers and dma requests latched until acknowledge
// [R2] request register readable, dma bits cleared by write
// [R3] timers share one level, timer 0 first
// [R4] status shows timer, each timer own type
// [R5] external pins only accepted in master mode
// [R6] each pin: priority, enable, trigger select
// [R7] edge needs rise, rearms after low clock
// [R8] pin requests follow the pin, unlatched
// [R9] requester holds pin high until acknowledged
// [R10] cascade pins run two acknowledge cycles
// [R11] each pin pair cascade or direct independently
// [R12] slave: pin a passes, request on pin d
// [R13] acknowledge sets in-service, clears request
// [R14] in-service blocks line unless special nesting
// [R15] master answers vector address, type times four
// [R16] fixed types per source in master mode
// [R17] equal priority resolved by default ranking
// [R18] internal 42 clocks, external 55 clocks
// [R19] slave type: vector bits and priority level
// [R20] slave select sampled at third state
// [R21] locked cycles, two idle states, waits
// [R22] type read from bus, acks exclusive
// [R23] mask one disables; level 0 highest
// [R24] request only for best unmasked pending source
`timescale 1ns/1ps
`include "irq_ctrl_regs.vh"
module irq_source_arbitration_response #(
  parameter RESP_INT = `RESP_INTERNAL,
  parameter RESP_EXT = `RESP_EXTERNAL
) (
  // clock and reset
  input wire i_clk,
  input wire i_rst_n,
  // apb slave
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  output reg [31:0] o_prdata,
  output reg o_pready,
  output reg o_pslverr,
  // internal sources, one-cycle pulses
  input wire [2:0] i_timer_evt,
  input wire [1:0] i_dma_evt,
  // external pins
  input wire i_ext_request_pin_a,
  input wire i_ext_request_pin_b,
  input wire i_ext_request_pin_c,
  input wire i_ext_request_pin_d,
  output reg o_ack_pulse_out_a,
  output reg o_ack_pulse_out_a_oe_n,
  output reg o_ack_pulse_out_b,
  output reg o_ack_pulse_out_b_oe_n,
  output reg o_slave_irq,
  // cpu side
  output reg o_cpu_irq,
  input wire i_ack_req,
  input wire i_bus_ready,
  input wire [7:0] i_bus_data,
  output reg [2:0] o_bus_status_lines,
  output reg o_lock,
  output reg o_resp_done,
  output reg [9:0] o_resp_vector,
  output reg o_resp_is_type
);
  localparam ST_IDLE = 5'b00001;
  localparam ST_WAIT = 5'b00010;
  localparam ST_ACK1 = 5'b00100;
  localparam ST_GAP = 5'b01000;
  localparam ST_ACK2 = 5'b10000;
  localparam [2:0] STAT_ACK = 3'h0;
  localparam [2:0] STAT_IDLE = 3'h7;

  reg [6:0] ctl_reg [0:`NSRC-1];
  reg [6:0] ctl_next;
  reg [`NSRC-1:0] inserv_reg;
  reg [2:0] tmr_pend_reg;
  reg [1:0] dma_pend_reg;
  reg [2:0] primask_reg;
  reg [4:0] vector_reg;
  reg slave_mode_reg;
  reg [3:0] pin_prev_reg;
  reg [3:0] edge_arm_reg;
  reg [4:0] state_reg;
  reg [5:0] cnt_reg;
  reg [2:0] win_reg;
  reg casc_b_reg;
  reg ext_vec_reg;
  reg sel_reg;
  reg [7:0] type_reg;
  reg [`NSRC-1:0] req;
  reg [`NSRC-1:0] elig;
  reg [2:0] best;
  reg best_ok;
  reg [2:0] lvl;
  reg [3:0] pins;
  integer i, j, k;

  function [2:0] pri_of;
    input [6:0] c;
    begin
      pri_of = c[`CTL_PRI_MSB:`CTL_PRI_LSB];
    end
  endfunction

  function [7:0] fixed_type;
    input [2:0] src;
    input [2:0] tp;
    begin
      case (src)
        `SRC_TMR: fixed_type = tp[0] ? `TYPE_TMR0 :
                  (tp[1] ? `TYPE_TMR1 : `TYPE_TMR2); // [R3] [R4] [R16]
        `SRC_DMA0: fixed_type = `TYPE_DMA0;
        `SRC_DMA1: fixed_type = `TYPE_DMA1;
        `SRC_EXTA: fixed_type = `TYPE_EXTA;
        `SRC_EXTB: fixed_type = `TYPE_EXTB;
        `SRC_EXTC: fixed_type = `TYPE_EXTC;
        default: fixed_type = `TYPE_EXTD;
      endcase
    end
  endfunction

  wire casc_a = ctl_reg[`SRC_EXTA][`CTL_CASC_BIT] & ~slave_mode_reg;
  wire casc_b = ctl_reg[`SRC_EXTB][`CTL_CASC_BIT] & ~slave_mode_reg;
  wire [11:0] waddr = i_paddr >> `ADDR_SHIFT;
  wire apb_acc = i_psel & i_penable & o_pready;
  wire apb_wr = apb_acc & i_pwrite;
  wire take = (state_reg == ST_WAIT) & i_ack_req;

  // pin request status
  always @* begin
    pins = {i_ext_request_pin_d, i_ext_request_pin_c,
            i_ext_request_pin_b, i_ext_request_pin_a};
    for (j = 0; j < 4; j = j + 1) begin
      if (slave_mode_reg) begin
        req[`SRC_EXTA + j] = 1'b0; // [R5]
      end else if ((j == 2 && casc_a) || (j == 3 && casc_b)) begin
        req[`SRC_EXTA + j] = 1'b0; // [R11]
      end else if (ctl_reg[`SRC_EXTA + j][`CTL_LEVEL_BIT]) begin
        req[`SRC_EXTA + j] = pins[j]; // [R8]
      end else begin
        req[`SRC_EXTA + j] = pins[j] & edge_arm_reg[j]; // [R7] [R8]
      end
    end
    req[`SRC_TMR] = |tmr_pend_reg; // [R1] [R3]
    req[`SRC_DMA0] = dma_pend_reg[0];
    req[`SRC_DMA1] = dma_pend_reg[1];
  end

  // arbitration: lowest level number wins, then lowest index
  always @* begin
    best = 3'h0;
    best_ok = 1'b0;
    lvl = 3'h7;
    for (k = 0; k < `NSRC; k = k + 1) begin
      elig[k] = req[k] & ~ctl_reg[k][`CTL_MASK_BIT] & // [R23]
        (~inserv_reg[k] | (ctl_reg[k][`CTL_NEST_BIT] &
        (k == `SRC_EXTA || k == `SRC_EXTB))) & // [R14]
        (pri_of(ctl_reg[k]) <= primask_reg); // [R24]
    end
    for (k = 0; k < `NSRC; k = k + 1) begin
      if (inserv_reg[k] && pri_of(ctl_reg[k]) < lvl) begin
        lvl = pri_of(ctl_reg[k]);
      end
    end
    for (k = `NSRC - 1; k >= 0; k = k - 1) begin
      if (elig[k] && (!best_ok || pri_of(ctl_reg[k]) <= pri_of(ctl_reg[best]))
          && (inserv_reg == 7'h00 || pri_of(ctl_reg[k]) < lvl ||
          inserv_reg[k])) begin
        best = k[2:0]; // [R17] [R24]
        best_ok = 1'b1;
      end
    end
  end

  always @* begin
    ctl_next = i_pwdata[6:0];
  end

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      for (i = 0; i < `NSRC; i = i + 1) begin
        ctl_reg[i] <= `CTL_RST;
      end
      inserv_reg <= 7'h00;
      tmr_pend_reg <= 3'h0;
      dma_pend_reg <= 2'h0;
      primask_reg <= `PRIMASK_RST;
      vector_reg <= `VECTOR_RST;
      slave_mode_reg <= 1'b0;
      pin_prev_reg <= 4'h0;
      edge_arm_reg <= 4'h0;
      state_reg <= ST_IDLE;
      cnt_reg <= 6'h00;
      win_reg <= 3'h0;
      casc_b_reg <= 1'b0;
      ext_vec_reg <= 1'b0;
      sel_reg <= 1'b0;
      type_reg <= 8'h00;
      o_prdata <= 32'h0;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_ack_pulse_out_a <= 1'b1;
      o_ack_pulse_out_a_oe_n <= 1'b1;
      o_ack_pulse_out_b <= 1'b1;
      o_ack_pulse_out_b_oe_n <= 1'b1;
      o_slave_irq <= 1'b0;
      o_cpu_irq <= 1'b0;
      o_bus_status_lines <= STAT_IDLE;
      o_lock <= 1'b0;
      o_resp_done <= 1'b0;
      o_resp_vector <= 10'h000;
      o_resp_is_type <= 1'b0;
    end else begin
      // edge detect: rearm after a low clock
      pin_prev_reg <= pins;
      for (i = 0; i < 4; i = i + 1) begin
        if (!pins[i]) begin
          edge_arm_reg[i] <= 1'b0; // [R7]
        end else if (!pin_prev_reg[i]) begin
          edge_arm_reg[i] <= 1'b1; // [R7]
        end
      end
      // apb: no wait states, pready high in first access phase cycle
      o_pready <= i_psel & ~i_penable;
      o_pslverr <= 1'b0;
      if (apb_wr) begin
        case (waddr)
          `OFF_TMR_CTL: ctl_reg[`SRC_TMR] <= ctl_next;
          `OFF_DMA0_CTL: ctl_reg[`SRC_DMA0] <= ctl_next;
          `OFF_DMA1_CTL: ctl_reg[`SRC_DMA1] <= ctl_next;
          `OFF_EXTA_CTL: ctl_reg[`SRC_EXTA] <= ctl_next; // [R6]
          `OFF_EXTB_CTL: ctl_reg[`SRC_EXTB] <= ctl_next;
          `OFF_EXTC_CTL: ctl_reg[`SRC_EXTC] <= ctl_next;
          `OFF_EXTD_CTL: ctl_reg[`SRC_EXTD] <= ctl_next;
          `OFF_PRIMASK: primask_reg <= i_pwdata[2:0];
          `OFF_VECTOR: vector_reg <= i_pwdata[7:3];
          `OFF_MODE: slave_mode_reg <= i_pwdata[0];
          `OFF_INSERV: inserv_reg <= i_pwdata[6:0];
          `OFF_EOS: inserv_reg[i_pwdata[2:0]] <= 1'b0;
          `OFF_MASK: begin
            for (i = 0; i < `NSRC; i = i + 1) begin
              ctl_reg[i][`CTL_MASK_BIT] <= i_pwdata[i];
            end
          end
          default: o_pslverr <= 1'b0;
        endcase
      end
      if (apb_wr && waddr == `OFF_REQ) begin
        dma_pend_reg <= i_pwdata[2:1]; // [R2]
      end
      if (apb_wr && waddr == `OFF_STATUS) begin
        tmr_pend_reg <= i_pwdata[2:0];
      end
      // new events win over software clears and acks
      if (take && best == `SRC_TMR) begin
        tmr_pend_reg <= (tmr_pend_reg & ~win_reg) | i_timer_evt;
      end else begin
        tmr_pend_reg <= (apb_wr && waddr == `OFF_STATUS ? i_pwdata[2:0] :
          tmr_pend_reg) | i_timer_evt; // [R1]
      end
      if (take && (best == `SRC_DMA0 || best == `SRC_DMA1)) begin
        dma_pend_reg <= (dma_pend_reg & ~(best == `SRC_DMA0 ? 2'b01 :
          2'b10)) | i_dma_evt; // [R13]
      end else begin
        dma_pend_reg <= (apb_wr && waddr == `OFF_REQ ? i_pwdata[2:1] :
          dma_pend_reg) | i_dma_evt; // [R1] [R2]
      end
      if (i_psel && !i_penable && !i_pwrite) begin
        case (waddr)
          `OFF_REQ: o_prdata <= {25'h0, req}; // [R2]
          `OFF_INSERV: o_prdata <= {25'h0, inserv_reg};
          `OFF_STATUS: o_prdata <= {29'h0, tmr_pend_reg}; // [R4]
          `OFF_PRIMASK: o_prdata <= {29'h0, primask_reg};
          `OFF_VECTOR: o_prdata <= {24'h0, vector_reg, 3'h0};
          `OFF_MODE: o_prdata <= {31'h0, slave_mode_reg};
          `OFF_TMR_CTL: o_prdata <= {25'h0, ctl_reg[`SRC_TMR]};
          `OFF_DMA0_CTL: o_prdata <= {25'h0, ctl_reg[`SRC_DMA0]};
          `OFF_DMA1_CTL: o_prdata <= {25'h0, ctl_reg[`SRC_DMA1]};
          `OFF_EXTA_CTL: o_prdata <= {25'h0, ctl_reg[`SRC_EXTA]};
          `OFF_EXTB_CTL: o_prdata <= {25'h0, ctl_reg[`SRC_EXTB]};
          `OFF_EXTC_CTL: o_prdata <= {25'h0, ctl_reg[`SRC_EXTC]};
          `OFF_EXTD_CTL: o_prdata <= {25'h0, ctl_reg[`SRC_EXTD]};
          default: o_prdata <= 32'h0;
        endcase
      end
      // timer winner, timer 0 first
      win_reg <= tmr_pend_reg[0] ? 3'b001 :
        (tmr_pend_reg[1] ? 3'b010 : 3'b100); // [R3]
      o_resp_done <= 1'b0;
      // slave mode request goes out on pin d; pin a bypasses us
      o_slave_irq <= slave_mode_reg & best_ok; // [R12]
      o_cpu_irq <= ~slave_mode_reg & best_ok &
        (state_reg == ST_IDLE || state_reg == ST_WAIT);
      case (state_reg)
        ST_IDLE: begin
          if (best_ok) begin
            state_reg <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (!best_ok) begin
            state_reg <= ST_IDLE; // [R8]
            o_cpu_irq <= 1'b0;
          end else if (i_ack_req) begin
            o_cpu_irq <= 1'b0;
            inserv_reg[best] <= 1'b1; // [R13]
            // edge pins need a fresh rise after acknowledge
            if (best >= `SRC_EXTA) begin
              edge_arm_reg[best - `SRC_EXTA] <= 1'b0; // [R7]
            end
            ext_vec_reg <= slave_mode_reg |
              (best == `SRC_EXTA && casc_a) ||
              (best == `SRC_EXTB && casc_b); // [R10]
            casc_b_reg <= best == `SRC_EXTB;
            type_reg <= slave_mode_reg ?
              {vector_reg, pri_of(ctl_reg[best])} : // [R19]
              fixed_type(best, tmr_pend_reg); // [R16]
            cnt_reg <= 6'h01;
            if (slave_mode_reg || (best == `SRC_EXTA && casc_a) ||
                (best == `SRC_EXTB && casc_b)) begin
              state_reg <= ST_ACK1;
              o_lock <= 1'b1; // [R21]
            end else begin
              state_reg <= ST_ACK2;
            end
          end
        end
        ST_ACK1: begin
          cnt_reg <= cnt_reg + 6'h01;
          o_bus_status_lines <= STAT_ACK; // [R22]
          if (!slave_mode_reg) begin
            o_ack_pulse_out_a_oe_n <= casc_b_reg; // [R10]
            o_ack_pulse_out_b_oe_n <= ~casc_b_reg;
            o_ack_pulse_out_a <= casc_b_reg;
            o_ack_pulse_out_b <= ~casc_b_reg; // [R22]
          end
          if (i_bus_ready) begin
            state_reg <= ST_GAP;
            win_reg <= 3'h0;
            o_ack_pulse_out_a <= 1'b1;
            o_ack_pulse_out_b <= 1'b1;
            o_bus_status_lines <= STAT_IDLE;
          end
        end
        ST_GAP: begin
          cnt_reg <= cnt_reg + 6'h01;
          win_reg <= win_reg + 3'h1;
          if (win_reg == `IDLE_STATES - 1) begin
            state_reg <= ST_ACK2; // [R21]
          end
        end
        ST_ACK2: begin
          cnt_reg <= cnt_reg + 6'h01;
          if (ext_vec_reg) begin
            o_bus_status_lines <= STAT_ACK;
            o_ack_pulse_out_a <= casc_b_reg | slave_mode_reg;
            o_ack_pulse_out_b <= ~casc_b_reg | slave_mode_reg;
            if (cnt_reg == 6'h06) begin
              sel_reg <= i_ext_request_pin_b; // [R20]
            end
          end
          if (cnt_reg >= (ext_vec_reg ? RESP_EXT : RESP_INT) - 1 &&
              (i_bus_ready || !ext_vec_reg)) begin // [R18]
            state_reg <= ST_IDLE;
            o_resp_done <= 1'b1;
            o_lock <= 1'b0;
            o_bus_status_lines <= STAT_IDLE;
            o_ack_pulse_out_a <= 1'b1;
            o_ack_pulse_out_b <= 1'b1;
            o_ack_pulse_out_a_oe_n <= 1'b1;
            o_ack_pulse_out_b_oe_n <= 1'b1;
            o_resp_is_type <= ext_vec_reg;
            if (!ext_vec_reg) begin
              o_resp_vector <= {type_reg, 2'b00}; // [R15]
            end else if (slave_mode_reg && sel_reg) begin
              o_resp_vector <= {2'b00, type_reg}; // [R20]
            end else begin
              o_resp_vector <= {2'b00, i_bus_data}; // [R22]
            end
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end
endmodule

// *** verif/cpu_partner.sv ***
/*
 behavioural cpu core and external controller on the far side.
 assumes the bench sets go, slow and type_val between responses.
*/
`timescale 1ns/1ps
module cpu_partner (
  input wire i_clk,
  input wire i_rst_n,
  input wire i_go,
  input wire i_slow,
  input wire [7:0] i_type_val,
  input wire i_cpu_irq,
  input wire i_slave_irq,
  input wire i_ack_a,
  input wire i_ack_b,
  input wire i_done,
  output logic o_ack_req,
  output logic o_bus_ready,
  output logic [7:0] o_bus_data
);
  logic busy_reg;
  logic [1:0] wait_reg;
  logic [7:0] junk_reg;
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_ack_req <= 1'b0;
      o_bus_ready <= 1'b0;
      o_bus_data <= 8'h00;
      busy_reg <= 1'b0;
      wait_reg <= 2'h0;
      junk_reg <= 8'h00;
    end else begin
      o_ack_req <= 1'b0;
      junk_reg <= junk_reg + 8'h35;
      if (i_go && !busy_reg && (i_cpu_irq || i_slave_irq)) begin
        o_ack_req <= 1'b1;
        busy_reg <= 1'b1;
      end else if (i_done) begin
        busy_reg <= 1'b0;
      end
      // a slow bus holds ready back two cycles in each ack cycle
      if (!i_ack_a || !i_ack_b) begin
        wait_reg <= (wait_reg == 2'h3) ? wait_reg : wait_reg + 2'h1;
        o_bus_ready <= !i_slow || wait_reg >= 2'h2;
        o_bus_data <= i_type_val;
      end else begin
        wait_reg <= 2'h0;
        o_bus_ready <= 1'b0;
        // released bus shows a moving pattern stepping by 0x35 each clock instead of the type
        o_bus_data <= junk_reg;
      end
    end
  end
endmodule

// *** verif/irq_resp_sva.sv ***
/*
 checker for the interrupt arbitration block, ports only.
 assumes one clock domain and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module irq_resp_sva #(
  parameter int RESP_INT = 42
) (
  input wire i_clk,
  input wire i_rst_n,
  input wire i_psel,
  input wire i_penable,
  input wire o_pready,
  input wire i_ack_req,
  input wire o_ack_pulse_out_a,
  input wire o_ack_pulse_out_a_oe_n,
  input wire o_ack_pulse_out_b,
  input wire o_ack_pulse_out_b_oe_n,
  input wire [2:0] o_bus_status_lines,
  input wire o_lock,
  input wire o_resp_done,
  input wire [9:0] o_resp_vector,
  input wire o_resp_is_type
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_ack_end;
    $rose(o_ack_pulse_out_a) || $rose(o_ack_pulse_out_b);
  endsequence
  sequence s_idle_two;
    (o_ack_pulse_out_a && o_ack_pulse_out_b)[*2];
  endsequence
  property p_ack_excl;
    !(!o_ack_pulse_out_a && !o_ack_pulse_out_b);
  endproperty
  property p_ack_status;
    (!o_ack_pulse_out_a || !o_ack_pulse_out_b) |-> o_bus_status_lines == 3'h0;
  endproperty
  property p_ack_lock;
    (!o_ack_pulse_out_a || !o_ack_pulse_out_b) |-> o_lock;
  endproperty
  property p_idle_gap;
    s_ack_end |-> s_idle_two;
  endproperty
  property p_oe_driven;
    !o_ack_pulse_out_a |-> !o_ack_pulse_out_a_oe_n;
  endproperty
  property p_oe_driven_b;
    !o_ack_pulse_out_b |-> !o_ack_pulse_out_b_oe_n;
  endproperty
  property p_int_time;
    o_resp_done && !o_resp_is_type |-> $past(i_ack_req, RESP_INT);
  endproperty
  property p_vec_addr;
    o_resp_done && !o_resp_is_type |-> o_resp_vector[1:0] == 2'h0;
  endproperty
  property p_pready;
    i_psel && !i_penable |=> o_pready;
  endproperty
  a_ack_excl: assert property (p_ack_excl) else $error("acks overlap");
  a_ack_status: assert property (p_ack_status)
    else $error("no ack status");
  a_ack_lock: assert property (p_ack_lock) else $error("ack not locked");
  a_idle_gap: assert property (p_idle_gap) else $error("idle gap short");
  a_oe_driven: assert property (p_oe_driven) else $error("ack a undriven");
  a_oe_driven_b: assert property (p_oe_driven_b)
    else $error("ack b undriven");
  a_int_time: assert property (p_int_time) else $error("internal time");
  a_vec_addr: assert property (p_vec_addr)
    else $error("vector unaligned");
  a_pready: assert property (p_pready) else $error("pready late");
endmodule

// *** verif/tb.sv ***
/*
 self-checking bench: apb register tasks and partner-driven acks.
 assumes the design answers apb and acknowledges within bounded time.
*/
`timescale 1ns/1ps
`include "irq_ctrl_regs.vh"
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin \
  err_total++; $display("ERROR %s exp %h got %h", nm, e, g); end end
module tb;
  logic i_clk = 0, i_rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, rd;
  logic [2:0] tmr = 0;
  logic [1:0] dma = 0;
  logic pa = 0, pb = 0, pc = 0, pd = 0, go = 0, slow = 0;
  logic [7:0] tval = 0, bdata;
  logic [31:0] prdata;
  logic pready, pslverr, aa, aa_oe, ab, ab_oe, sirq, cirq, ack, brdy;
  logic [2:0] bst;
  logic lock, done, istype;
  logic [9:0] vec;
  int err_total = 0, compares = 0, n;
  always #2.5 i_clk = ~i_clk;
  irq_source_arbitration_response i_irq_source_arbitration_response (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_timer_evt(tmr), .i_dma_evt(dma), .i_ext_request_pin_a(pa),
    .i_ext_request_pin_b(pb), .i_ext_request_pin_c(pc),
    .i_ext_request_pin_d(pd), .o_ack_pulse_out_a(aa),
    .o_ack_pulse_out_a_oe_n(aa_oe), .o_ack_pulse_out_b(ab),
    .o_ack_pulse_out_b_oe_n(ab_oe), .o_slave_irq(sirq), .o_cpu_irq(cirq),
    .i_ack_req(ack), .i_bus_ready(brdy), .i_bus_data(bdata),
    .o_bus_status_lines(bst), .o_lock(lock), .o_resp_done(done),
    .o_resp_vector(vec), .o_resp_is_type(istype));
  cpu_partner i_cpu_partner (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_go(go),
    .i_slow(slow), .i_type_val(tval), .i_cpu_irq(cirq), .i_slave_irq(sirq),
    .i_ack_a(aa), .i_ack_b(ab), .i_done(done), .o_ack_req(ack),
    .o_bus_ready(brdy), .o_bus_data(bdata));
  task automatic apb(input logic wr, input logic [11:0] off,
                     input logic [31:0] wd);
    int k;
    k = 0;
    @(posedge i_clk);
    psel <= 1; penable <= 0; pwrite <= wr; pwdata <= wd;
    paddr <= off << `ADDR_SHIFT;
    @(posedge i_clk);
    penable <= 1;
    do begin @(posedge i_clk); k++; end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    if (k >= 50) err_total++;
    psel <= 0; penable <= 0;
  endtask
  task automatic wait_done(input int lim);
    n = 0;
    do begin @(posedge i_clk); n++; end while (done !== 1'b1 && n < lim);
    `CHK("done", 1'b1, done)
  endtask
  task automatic idle(input int c);
    repeat (c) @(posedge i_clk);
  endtask
  task test_done;
    $display("compares %0d errors %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #100000;
    err_total++;
    test_done();
  end
  initial begin
    idle(3);
    i_rst_n <= 1;
    apb(0, `OFF_DMA1_CTL, 0); `CHK("ctl rst", 32'h0f, rd)
    apb(0, `OFF_PRIMASK, 0); `CHK("primask rst", 32'h7, rd)
    apb(0, 12'h07c, 0); `CHK("unmapped", 32'h0, rd)
    // latched dma request, cleared by software
    dma <= 2'b01; idle(1); dma <= 0; idle(2);
    apb(0, `OFF_REQ, 0); `CHK("dma latch", 1'b1, rd[`SRC_DMA0])
    apb(1, `OFF_REQ, 0); apb(0, `OFF_REQ, 0);
    `CHK("dma clear", 1'b0, rd[`SRC_DMA0])
    // timer 1 through the shared timer line
    apb(1, `OFF_TMR_CTL, 32'h01);
    tmr <= 3'b010; idle(1); tmr <= 0; idle(2);
    apb(0, `OFF_STATUS, 0); `CHK("tmr status", 3'b010, rd[2:0])
    go <= 1; wait_done(100);
    `CHK("tmr1 vec", {`TYPE_TMR1, 2'b00}, vec)
    `CHK("n 42", 1'b1, n >= `RESP_INTERNAL)
    go <= 0;
    apb(0, `OFF_INSERV, 0); `CHK("inserv", 1'b1, rd[`SRC_TMR])
    apb(0, `OFF_REQ, 0); `CHK("req clr", 1'b0, rd[`SRC_TMR])
    apb(1, `OFF_EOS, `SRC_TMR);
    // two timers at once: timer 0 first
    tmr <= 3'b101; idle(1); tmr <= 0; go <= 1; wait_done(100);
    `CHK("tmr0 first", {`TYPE_TMR0, 2'b00}, vec)
    apb(1, `OFF_EOS, `SRC_TMR); wait_done(100);
    `CHK("tmr2 next", {`TYPE_TMR2, 2'b00}, vec)
    go <= 0; apb(1, `OFF_EOS, `SRC_TMR);
    // equal programmed priority resolved by default ranking
    apb(1, `OFF_DMA0_CTL, 32'h02); apb(1, `OFF_DMA1_CTL, 32'h02);
    dma <= 2'b11; idle(1); dma <= 0; go <= 1; wait_done(100);
    `CHK("dma0 first", {`TYPE_DMA0, 2'b00}, vec)
    idle(50); apb(0, `OFF_REQ, 0);
    `CHK("dma1 held", 1'b1, rd[`SRC_DMA1])
    apb(1, `OFF_EOS, `SRC_DMA0); wait_done(100);
    `CHK("dma1 next", {`TYPE_DMA1, 2'b00}, vec)
    go <= 0; apb(1, `OFF_EOS, `SRC_DMA1);
    // level pin b follows the pin
    apb(1, `OFF_EXTB_CTL, 32'h13); pb <= 1; idle(3);
    apb(0, `OFF_REQ, 0); `CHK("pin b req", 1'b1, rd[`SRC_EXTB])
    pb <= 0; idle(3);
    apb(0, `OFF_REQ, 0); `CHK("pin b drop", 1'b0, rd[`SRC_EXTB])
    // edge pin c: one request per rise, pin held until ack
    apb(1, `OFF_EXTC_CTL, 32'h04); pc <= 1; go <= 1; wait_done(100);
    `CHK("pin c vec", {`TYPE_EXTC, 2'b00}, vec)
    go <= 0; apb(1, `OFF_EOS, `SRC_EXTC); idle(3);
    apb(0, `OFF_REQ, 0); `CHK("no rearm", 1'b0, rd[`SRC_EXTC])
    pc <= 0; idle(2); pc <= 1; idle(3);
    apb(0, `OFF_REQ, 0); `CHK("rearm", 1'b1, rd[`SRC_EXTC])
    pc <= 0; apb(1, `OFF_EXTC_CTL, 32'h0f);
    // cascaded pin a with a slow external controller
    apb(1, `OFF_EXTA_CTL, 32'h20); tval <= 8'h5a; slow <= 1;
    pa <= 1; go <= 1; wait_done(300);
    `CHK("casc type", 8'h5a, vec[7:0])
    `CHK("casc is type", 1'b1, istype)
    `CHK("n 55", 1'b1, n >= `RESP_EXTERNAL)
    go <= 0; pa <= 0; apb(1, `OFF_EOS, `SRC_EXTA);
    // slave mode: pin b ignored, timer request raises the slave irq
    apb(1, `OFF_MODE, 1); apb(1, `OFF_VECTOR, 32'ha8);
    pb <= 1; idle(3); apb(0, `OFF_REQ, 0);
    `CHK("slave pin", 1'b0, rd[`SRC_EXTB])
    pb <= 0; tmr <= 3'b001; idle(1); tmr <= 0; idle(3);
    `CHK("slave irq", 1'b1, sirq)
    test_done();
  end
endmodule
bind irq_source_arbitration_response irq_resp_sva #(.RESP_INT(RESP_INT))
  i_irq_resp_sva (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(i_psel),
  .i_penable(i_penable), .o_pready(o_pready), .i_ack_req(i_ack_req),
  .o_ack_pulse_out_a(o_ack_pulse_out_a),
  .o_ack_pulse_out_a_oe_n(o_ack_pulse_out_a_oe_n),
  .o_ack_pulse_out_b(o_ack_pulse_out_b),
  .o_ack_pulse_out_b_oe_n(o_ack_pulse_out_b_oe_n),
  .o_bus_status_lines(o_bus_status_lines), .o_lock(o_lock),
  .o_resp_done(o_resp_done), .o_resp_vector(o_resp_vector),
  .o_resp_is_type(o_resp_is_type));
